// file: rtl/csm_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
// How it works
// - Reset state holds CPU, peripherals initialized, stopped
// - Low reset pin aborts all, masks interrupts
// - Rising reset pin starts reset exception handling
// - Watchdog overflow also enters reset state
// - Exceptions pass through vector fetch state
// - Execution state runs instructions in sequence
// - Sleep or hardware standby enters stop state
// - Straps: hi-lo mode 2, lo-bit-high mode 3
// - Monitor bit 7 reserved, writable, resets 0
// - Monitor bits 6..2 read zero, ignore writes
// - Monitor bits 1..0 show straps, read-only
// - Straps latched on monitor read, only reset_n releases
// - Sense bits after reset_n follow strap levels
module csm_ctrl
  import csm_pkg::*;
#(
  parameter int VEC_CYC = VEC_LOAD_CYC
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic chip_reset_low,
  input wire logic wdt_overflow,
  input wire logic mode_strap_hi,
  input wire logic mode_strap_lo,
  input wire csm_evt_t evt,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  output csm_ctl_t ctl,
  output logic [1:0] mcu_mode,
  output logic adv_addressing,
  output logic rom_enable,
  output logic wdt_reset_seen
);
  if (VEC_CYC < 1 || VEC_CYC > 255) begin : g_bad_vec
    $error("VEC_CYC out of range");
  end

  // ---------------------------------------------------------------
  // Reset request
  // ---------------------------------------------------------------
  logic rst_req;
  logic rst_req_q;
  logic rst_release;
  assign rst_req = !chip_reset_low || wdt_overflow;
  assign rst_release = rst_req_q && !rst_req;

  // ---------------------------------------------------------------
  // Processing state machine
  // ---------------------------------------------------------------
  csm_state_t state_q, state_d;
  logic [7:0] cnt_q, cnt_d;
  logic cnt_done;
  assign cnt_done = (cnt_q == 8'(VEC_CYC - 1));

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    case (state_q)
      ST_RESET: begin
        cnt_d = 8'h00;
        if (rst_release) begin
          state_d = ST_EXCEPT;
        end
      end
      ST_EXCEPT: begin
        cnt_d = cnt_q + 8'h01;
        if (cnt_done) begin
          state_d = ST_RUN;
          cnt_d = 8'h00;
        end
      end
      ST_RUN: begin
        if (evt.exc_req) begin
          state_d = ST_EXCEPT;
        end else if (evt.sleep_exec || evt.hw_standby) begin
          state_d = ST_STOP;
        end
      end
      ST_STOP: begin
        if (evt.wake) begin
          state_d = ST_EXCEPT;
        end
      end
      default: state_d = ST_RESET;
    endcase
    if (rst_req) begin
      state_d = ST_RESET;
      cnt_d = 8'h00;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= ST_RESET;
      cnt_q <= 8'h00;
      rst_req_q <= 1'b1;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      rst_req_q <= rst_req;
    end
  end

  // Reset source flag
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wdt_reset_seen <= 1'b0;
    end else if (wdt_overflow) begin
      wdt_reset_seen <= 1'b1;
    end else if (!chip_reset_low) begin
      wdt_reset_seen <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Control outputs
  // ---------------------------------------------------------------
  logic in_reset;
  assign in_reset = (state_q == ST_RESET);
  assign ctl.periph_hold = in_reset;
  assign ctl.cpu_halt = in_reset || (state_q == ST_STOP);
  assign ctl.irq_mask = in_reset;
  assign ctl.vec_fetch = (state_q == ST_EXCEPT);
  assign ctl.cpu_run = (state_q == ST_RUN);

  // ---------------------------------------------------------------
  // Mode sense latch
  // ---------------------------------------------------------------
  logic rd_mon;
  logic wr_mon;
  logic acc;
  logic hit_mon;
  logic hit_stat;
  logic hit_ctrl;
  logic [1:0] sense_q;
  logic sense_live_q;
  logic rsv_q;
  assign acc = psel && penable;
  assign hit_mon = (paddr == MON_OFFSET);
  assign hit_stat = (paddr == STAT_OFFSET);
  assign hit_ctrl = (paddr == CTRL_OFFSET);
  assign rd_mon = acc && !pwrite && hit_mon;
  assign wr_mon = acc && pwrite && hit_mon;

  // Sense follows straps until first monitor read, then relatches only on each monitor read
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sense_live_q <= 1'b1;
      sense_q <= 2'h0;
    end else begin
      if (sense_live_q || rd_mon) begin
        sense_q <= {mode_strap_hi, mode_strap_lo};
      end
      if (rd_mon) begin
        sense_live_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rsv_q <= RSV_RESET;
    end else if (wr_mon) begin
      rsv_q <= pwdata[RSV_BIT];
    end
  end

  // ---------------------------------------------------------------
  // Mode decode
  // ---------------------------------------------------------------
  logic [1:0] cur_sense;
  assign cur_sense = sense_live_q ? {mode_strap_hi, mode_strap_lo} : sense_q;
  assign mcu_mode = (cur_sense == STRAP_MODE2) ? MODE_NUM2 :
                    cur_sense[0] ? MODE_NUM3 : MODE_BAD;
  assign adv_addressing = (mcu_mode == MODE_NUM2);
  assign rom_enable = (mcu_mode == MODE_NUM2);

  // ---------------------------------------------------------------
  // APB read data
  // ---------------------------------------------------------------
  logic [7:0] mon_val;
  logic [31:0] rd_d;
  assign mon_val = {rsv_q, ZERO_FIELD, {mode_strap_hi, mode_strap_lo}};
  assign rd_d = hit_mon ? {24'h000000, mon_val} :
                hit_stat ? {28'h0000000, 2'(state_q), 1'b0,
                            wdt_reset_seen} :
                hit_ctrl ? {30'h0, mcu_mode} : 32'h00000000;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rd_d;
    end
  end

  assign pready = 1'b1;
  assign pslverr = acc && !(hit_mon || hit_stat || hit_ctrl);

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  property p_reset_hold;
    @(posedge clk_sys) disable iff (!reset_n)
    rst_req |=> (state_q == ST_RESET) && ctl.irq_mask && ctl.periph_hold;
  endproperty
  a_reset_hold: assert property (p_reset_hold)
    else $error("reset request did not hold reset state");

  property p_wdt_reset;
    @(posedge clk_sys) disable iff (!reset_n)
    wdt_overflow |=> ctl.cpu_halt && !ctl.cpu_run;
  endproperty
  a_wdt_reset: assert property (p_wdt_reset)
    else $error("watchdog overflow did not reset");

  property p_release_exc;
    @(posedge clk_sys) disable iff (!reset_n)
    (state_q == ST_RESET) && rst_release |=> ctl.vec_fetch;
  endproperty
  a_release_exc: assert property (p_release_exc)
    else $error("reset release did not start exception");

  property p_exc_to_run;
    @(posedge clk_sys) disable iff (!reset_n)
    $rose(ctl.vec_fetch) |-> ##[1:255] (ctl.cpu_run || ctl.periph_hold);
  endproperty
  a_exc_to_run: assert property (p_exc_to_run)
    else $error("exception state did not end");

  property p_sleep_stop;
    @(posedge clk_sys) disable iff (!reset_n)
    ctl.cpu_run && (evt.sleep_exec || evt.hw_standby) && !evt.exc_req
      && !rst_req |=> ctl.cpu_halt && !ctl.periph_hold;
  endproperty
  a_sleep_stop: assert property (p_sleep_stop)
    else $error("sleep did not stop the processor");

  property p_mode_decode;
    @(posedge clk_sys) disable iff (!reset_n)
    sense_live_q && mode_strap_lo |-> mcu_mode == MODE_NUM3 && !rom_enable;
  endproperty
  a_mode_decode: assert property (p_mode_decode)
    else $error("mode 3 decode wrong");

  property p_zero_bits;
    @(posedge clk_sys) disable iff (!reset_n)
    rd_mon |=> prdata[6:2] == ZERO_FIELD && prdata[31:8] == 24'h000000;
  endproperty
  a_zero_bits: assert property (p_zero_bits)
    else $error("monitor zero bits not zero");

  property p_rsv_write;
    @(posedge clk_sys) disable iff (!reset_n)
    wr_mon |=> rsv_q == $past(pwdata[RSV_BIT]);
  endproperty
  a_rsv_write: assert property (p_rsv_write)
    else $error("reserved bit write lost");

  property p_latch_read;
    @(posedge clk_sys) disable iff (!reset_n)
    rd_mon |=> !sense_live_q
      && sense_q == $past({mode_strap_hi, mode_strap_lo});
  endproperty
  a_latch_read: assert property (p_latch_read)
    else $error("strap levels not latched on read");

  property p_sense_live;
    @(posedge clk_sys) disable iff (!reset_n)
    $rose(reset_n) |-> sense_live_q;
  endproperty
  a_sense_live: assert property (p_sense_live)
    else $error("sense not following straps after reset");

  property p_wdt_flag;
    @(posedge clk_sys) disable iff (!reset_n)
    wdt_overflow |=> wdt_reset_seen;
  endproperty
  a_wdt_flag: assert property (p_wdt_flag)
    else $error("watchdog reset source not flagged");

  property p_mode2_decode;
    @(posedge clk_sys) disable iff (!reset_n)
    sense_live_q && mode_strap_hi && !mode_strap_lo
      |-> mcu_mode == MODE_NUM2 && rom_enable && adv_addressing;
  endproperty
  a_mode2_decode: assert property (p_mode2_decode)
    else $error("mode 2 decode wrong");

  property p_stop_wake;
    @(posedge clk_sys) disable iff (!reset_n)
    ctl.cpu_halt && !ctl.periph_hold && evt.wake && !rst_req
      |=> ctl.vec_fetch;
  endproperty
  a_stop_wake: assert property (p_stop_wake)
    else $error("wake from stop did not fetch vector");
endmodule
`default_nettype wire

// file: rtl/csm_pkg.sv
package csm_pkg;
  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] MON_OFFSET = 8'h00;
  localparam logic [7:0] STAT_OFFSET = 8'h04;
  localparam logic [7:0] CTRL_OFFSET = 8'h08;
  localparam int RSV_BIT = 7;
  localparam int SENSE_HI_BIT = 1;
  localparam int SENSE_LO_BIT = 0;
  localparam logic RSV_RESET = 1'b0;
  localparam logic [4:0] ZERO_FIELD = 5'h00;
  // ---------------------------------------------------------------
  // Mode codes
  // ---------------------------------------------------------------
  localparam logic [1:0] STRAP_MODE2 = 2'h2;
  localparam logic [1:0] MODE_NUM2 = 2'h2;
  localparam logic [1:0] MODE_NUM3 = 2'h3;
  localparam logic [1:0] MODE_BAD = 2'h0;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_NS = 25;
  localparam int VEC_LOAD_NS = 100;
  localparam int VEC_LOAD_CYC = (VEC_LOAD_NS + CLK_NS - 1) / CLK_NS;

  typedef enum {
    ST_RESET,
    ST_EXCEPT,
    ST_RUN,
    ST_STOP
  } csm_state_t;

  typedef struct packed {
    logic sleep_exec;
    logic hw_standby;
    logic wake;
    logic exc_req;
  } csm_evt_t;

  typedef struct packed {
    logic periph_hold;
    logic cpu_halt;
    logic irq_mask;
    logic vec_fetch;
    logic cpu_run;
  } csm_ctl_t;
endpackage

// file: verif/cpu_state_and_mode_select_test.sv
`timescale 1ns/100ps
`default_nettype none
module cpu_state_and_mode_select_test;
  import csm_pkg::*;
  // ------------------------------------------
  // Signals and instances
  // ------------------------------------------
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic wdt_overflow = 1'b0;
  logic hold_rst = 1'b0;
  logic [1:0] strap_req = 2'h2;
  csm_evt_t evt = '0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] lfsr = 32'h00011cb8;
  logic [31:0] prdata;
  logic chip_reset_low, mode_strap_hi, mode_strap_lo, pready, pslverr;
  logic [1:0] mcu_mode;
  logic adv_addressing, rom_enable, wdt_reset_seen;
  csm_ctl_t ctl;
  int failures = 0;
  int comparisons = 0;
  logic [32:0] exp_q[$];

  always #12.5 clk_sys = ~clk_sys;

  csm_board board (.clk_sys, .hold_rst, .strap_req, .chip_reset_low,
    .mode_strap_hi, .mode_strap_lo);
  csm_ctrl uut (.clk_sys, .reset_n, .chip_reset_low, .wdt_overflow,
    .mode_strap_hi, .mode_strap_lo, .evt, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pready, .prdata, .pslverr, .ctl,
    .mcu_mode, .adv_addressing, .rom_enable, .wdt_reset_seen);

  // ------------------------------------------
  // Tasks
  // ------------------------------------------
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction

  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask

  task automatic ev(input logic [3:0] e);
    @(posedge clk_sys);
    evt <= e;
    @(posedge clk_sys);
    evt <= '0;
  endtask

  task automatic look(input logic [9:0] e);
    @(posedge clk_sys);
    comparisons++;
    if ({ctl, mcu_mode, adv_addressing, rom_enable, wdt_reset_seen} !== e) begin
      failures++;
      $display("[ERR] %0t output mismatch", $time);
    end
  endtask

  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // ------------------------------------------
  // Read checker
  // ------------------------------------------
  always @(posedge clk_sys) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      comparisons++;
      if (exp_q.size() == 0 || {pslverr, prdata} !== exp_q.pop_front()) begin
        failures++;
        $display("[ERR] %0t read mismatch at %h", $time, paddr);
      end
    end
  end

  // ------------------------------------------
  // Sequence
  // ------------------------------------------
  initial begin
    logic [31:0] w;
    idle(6);
    reset_n <= 1'b1;
    idle(10);
    rd(CTRL_OFFSET, 33'h2);
    rd(STAT_OFFSET, 33'h8);
    look(10'h036);
    rd(MON_OFFSET, 33'h2);
    hold_rst <= 1'b1;
    idle(3);
    strap_req <= 2'h1;
    idle(2);
    hold_rst <= 1'b0;
    idle(10);
    rd(CTRL_OFFSET, 33'h2);
    reset_n <= 1'b0;
    idle(2);
    reset_n <= 1'b1;
    idle(10);
    rd(CTRL_OFFSET, 33'h3);
    repeat (4) begin
      w = rnd();
      w[7] = 1'b0;
      apb(1'b1, MON_OFFSET, w);
      rd(MON_OFFSET, {25'h0, w[7], 5'h0, 2'h1});
    end
    apb(1'b1, MON_OFFSET, 32'h0);
    rd(MON_OFFSET, 33'h1);
    rd(8'h0c, 33'h100000000);
    ev(4'h1);
    rd(STAT_OFFSET, 33'h4);
    idle(8);
    rd(STAT_OFFSET, 33'h8);
    for (int i = 0; i < 2; i++) begin
      ev(i ? 4'h8 : 4'h4);
      idle(2);
      rd(STAT_OFFSET, 33'hc);
      look(10'h118);
      ev(4'h2);
      rd(STAT_OFFSET, 33'h4);
      idle(8);
      rd(STAT_OFFSET, 33'h8);
    end
    hold_rst <= 1'b1;
    idle(4);
    rd(STAT_OFFSET, 33'h0);
    look(10'h398);
    hold_rst <= 1'b0;
    idle(10);
    rd(STAT_OFFSET, 33'h8);
    wdt_overflow <= 1'b1;
    idle(3);
    wdt_overflow <= 1'b0;
    idle(10);
    rd(STAT_OFFSET, 33'h9);
    look(10'h039);
    idle(4);
    final_report();
  end

  initial begin
    #100000;
    failures++;
    final_report();
  end
endmodule
`default_nettype wire

// file: verif/csm_board.sv
`timescale 1ns/100ps
`default_nettype none
// ------------------------------------------
// Board reset line and mode straps
// ------------------------------------------
module csm_board (
  input wire logic clk_sys,
  input wire logic hold_rst,
  input wire logic [1:0] strap_req,
  output logic chip_reset_low,
  output logic mode_strap_hi,
  output logic mode_strap_lo
);
  always_ff @(posedge clk_sys) begin
    chip_reset_low <= !hold_rst;
    {mode_strap_hi, mode_strap_lo} <= strap_req;
  end
endmodule
`default_nettype wire
